// ### srs_pkg.sv
package srs_pkg;

  localparam int unsigned SRS_NUM_SETS = 11;
  localparam int unsigned SRS_SET_W    = 4;
  localparam int unsigned SRS_DATA_W   = 16;

  // ---------------------------------------------------------------------------
  // Set numbers
  // ---------------------------------------------------------------------------
  localparam logic [3:0] SRS_SET_SENSOR     = 4'h0;
  localparam logic [3:0] SRS_SET_OPER       = 4'h1;
  localparam logic [3:0] SRS_SET_OPER_LAST  = 4'h7;
  localparam logic [3:0] SRS_SET_QUES       = 4'h8;
  localparam logic [3:0] SRS_SET_QUES_LAST  = 4'hA;

  // ---------------------------------------------------------------------------
  // Operation codes
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRS_OP_COND = 3'b000,
    SRS_OP_EVENT = 3'b001,
    SRS_OP_ENABLE = 3'b010,
    SRS_OP_FALL = 3'b011,
    SRS_OP_RISE = 3'b100
  } srs_op_t;

  typedef enum logic [1:0] {
    SRS_ST_IDLE = 2'b00,
    SRS_ST_EXEC = 2'b01,
    SRS_ST_RESP = 2'b10
  } srs_state_t;

  // ---------------------------------------------------------------------------
  // Field layout and preset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] SRS_VALID_MASK  = 16'h7FFF;
  localparam int unsigned SRS_BIT_CONN_A  = 1;
  localparam int unsigned SRS_BIT_ERR_A   = 3;
  localparam int unsigned SRS_BIT_REAR_A  = 5;
  localparam int unsigned SRS_BIT_KEY     = 14;
  localparam logic [15:0] SRS_SENSOR_MASK = 16'h007E;
  localparam logic [15:0] SRS_KEY_MASK    = 16'h4000;
  localparam logic [15:0] SRS_PRE_ENABLE  = 16'h0000;
  localparam logic [15:0] SRS_PRE_RISE    = 16'h7FFF;
  localparam logic [15:0] SRS_PRE_FALL    = 16'h0000;
  localparam logic        SRS_PRE_QUEUE_EN = 1'b1;

endpackage

// ### srs_sensor_cond.sv
`timescale 1ns/1ps
`default_nettype none
module srs_sensor_cond
  import srs_pkg::*;
(
  input  wire logic [1:0]  i_present,
  input  wire logic [1:0]  i_rear,
  input  wire logic [1:0]  i_cal_fail,
  input  wire logic [1:0]  i_both_ports,
  output logic      [15:0] o_cond
);
  always_comb begin
    o_cond = 16'h0000;
    o_cond[SRS_BIT_CONN_A +: 2] = i_present;
    o_cond[SRS_BIT_ERR_A +: 2]  = i_cal_fail | i_both_ports;
    o_cond[SRS_BIT_REAR_A +: 2] = i_rear & i_present;
    o_cond = o_cond & SRS_SENSOR_MASK;
  end
endmodule
`default_nettype wire

// ### srs_reg_set.sv
`timescale 1ns/1ps
`default_nettype none
module srs_reg_set
  import srs_pkg::*;
#(
  parameter logic [15:0] P_PRE_ENABLE = 16'h0000,
  parameter logic [15:0] P_PRE_RISE   = 16'h7FFF,
  parameter logic [15:0] P_PRE_FALL   = 16'h0000,
  parameter bit          P_PRESET_FILT = 1'b1
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic [15:0] i_cond,
  input  wire logic [15:0] i_direct_set,
  input  wire logic        i_preset,
  input  wire logic        i_clear_events,
  input  wire logic        i_read_event,
  input  wire logic        i_wr_enable,
  input  wire logic        i_wr_fall,
  input  wire logic        i_wr_rise,
  input  wire logic [15:0] i_wdata,
  output logic      [15:0] o_cond,
  output logic      [15:0] o_event,
  output logic      [15:0] o_enable,
  output logic      [15:0] o_fall,
  output logic      [15:0] o_rise,
  output logic             o_summary
);
  logic [15:0] cond_prev_q;
  logic [15:0] event_q;
  logic [15:0] enable_q;
  logic [15:0] fall_q;
  logic [15:0] rise_q;
  logic [15:0] edge_set;

  assign edge_set = ((i_cond & ~cond_prev_q & rise_q) | (~i_cond & cond_prev_q & fall_q)
                    | i_direct_set) & SRS_VALID_MASK;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cond_prev_q <= 16'h0000;
    end else if (i_ce) begin
      cond_prev_q <= i_cond;
    end
  end

  // A new edge in the cycle of the clearing read survives the clear.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      event_q <= 16'h0000;
    end else if (i_ce) begin
      if (i_read_event || i_clear_events) begin
        event_q <= edge_set;
      end else begin
        event_q <= event_q | edge_set;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      enable_q <= P_PRE_ENABLE & SRS_VALID_MASK;
    end else if (i_ce) begin
      if (i_preset) begin
        enable_q <= P_PRE_ENABLE & SRS_VALID_MASK;
      end else if (i_wr_enable) begin
        enable_q <= i_wdata & SRS_VALID_MASK;
      end
    end
  end

  // Sets whose filters the preset does not touch keep what was last written.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      fall_q <= P_PRE_FALL & SRS_VALID_MASK;
      rise_q <= P_PRE_RISE & SRS_VALID_MASK;
    end else if (i_ce) begin
      if (i_preset && P_PRESET_FILT) begin
        fall_q <= P_PRE_FALL & SRS_VALID_MASK;
        rise_q <= P_PRE_RISE & SRS_VALID_MASK;
      end else begin
        if (i_wr_fall) begin
          fall_q <= i_wdata & SRS_VALID_MASK;
        end
        if (i_wr_rise) begin
          rise_q <= i_wdata & SRS_VALID_MASK;
        end
      end
    end
  end

  assign o_cond    = i_cond & SRS_VALID_MASK;
  assign o_event   = event_q;
  assign o_enable  = enable_q;
  assign o_fall    = fall_q;
  assign o_rise    = rise_q;
  assign o_summary = |(event_q & enable_q);

  chk_bit15_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !enable_q[15] && !fall_q[15] && !rise_q[15] && !event_q[15])
    else $error("bit 15 of a set register is not zero");
  chk_rise_latch: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && !i_preset && (i_cond & ~cond_prev_q & rise_q) != 16'h0000)
      |=> ((event_q & $past(i_cond & ~cond_prev_q & rise_q)) == $past(i_cond & ~cond_prev_q & rise_q)))
    else $error("rising edge did not latch the event");
  chk_fall_latch: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && (~i_cond & cond_prev_q & fall_q) != 16'h0000)
      |=> ((event_q & $past(~i_cond & cond_prev_q & fall_q)) == $past(~i_cond & cond_prev_q & fall_q)))
    else $error("falling edge did not latch the event");
endmodule
`default_nettype wire

// ### srs_top.sv
`timescale 1ns/1ps
`default_nettype none
module srs_top
  import srs_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic        i_cmd_valid,
  input  wire logic [3:0]  i_cmd_set,
  input  wire logic [2:0]  i_cmd_op,
  input  wire logic        i_cmd_write,
  input  wire logic [15:0] i_cmd_wdata,
  input  wire logic        i_clear_status,
  input  wire logic        i_status_preset,
  input  wire logic [1:0]  i_sensor_present,
  input  wire logic [1:0]  i_sensor_rear,
  input  wire logic [1:0]  i_sensor_cal_fail,
  input  wire logic [1:0]  i_sensor_both_ports,
  input  wire logic        i_key_press,
  input  wire logic [15:0] i_oper_cond_0,
  input  wire logic [15:0] i_oper_cond_1,
  input  wire logic [15:0] i_oper_cond_2,
  input  wire logic [15:0] i_oper_cond_3,
  input  wire logic [15:0] i_oper_cond_4,
  input  wire logic [15:0] i_oper_cond_5,
  input  wire logic [15:0] i_oper_cond_6,
  input  wire logic [15:0] i_ques_cond_0,
  input  wire logic [15:0] i_ques_cond_1,
  input  wire logic [15:0] i_ques_cond_2,
  output logic             o_cmd_ready,
  output logic             o_rsp_valid,
  output logic [15:0]      o_rsp_data,
  output logic             o_rsp_error,
  output logic [10:0]      o_summary,
  output logic             o_queue_enable,
  output logic             o_clear_queue
);
  // ---------------------------------------------------------------------------
  // Per-set condition inputs
  // ---------------------------------------------------------------------------
  logic [15:0] sensor_cond;
  logic [15:0] cond_in   [SRS_NUM_SETS];
  logic [15:0] direct_in [SRS_NUM_SETS];
  logic [15:0] cond_rd   [SRS_NUM_SETS];
  logic [15:0] event_rd  [SRS_NUM_SETS];
  logic [15:0] enable_rd [SRS_NUM_SETS];
  logic [15:0] fall_rd   [SRS_NUM_SETS];
  logic [15:0] rise_rd   [SRS_NUM_SETS];
  logic [10:0] summary;
  logic [10:0] rd_event_sel;
  logic [10:0] wr_en_sel;
  logic [10:0] wr_fall_sel;
  logic [10:0] wr_rise_sel;

  srs_state_t  state_q;
  logic [3:0]  set_q;
  logic [2:0]  op_q;
  logic        write_q;
  logic [15:0] wdata_q;
  logic        rsp_valid_q;
  logic [15:0] rsp_data_q;
  logic        rsp_error_q;
  logic        cmd_ready_q;
  logic [10:0] summary_q;
  logic        queue_en_q;
  logic        clear_queue_q;
  logic        exec;
  logic        bad_cmd;

  srs_sensor_cond u_sensor_cond (
    .i_present    (i_sensor_present),
    .i_rear       (i_sensor_rear),
    .i_cal_fail   (i_sensor_cal_fail),
    .i_both_ports (i_sensor_both_ports),
    .o_cond       (sensor_cond)
  );

  always_comb begin
    for (int k = 0; k < SRS_NUM_SETS; k++) begin
      direct_in[k] = 16'h0000;
    end
    cond_in[0]  = sensor_cond;
    direct_in[0] = i_key_press ? SRS_KEY_MASK : 16'h0000;
    cond_in[1]  = i_oper_cond_0;
    cond_in[2]  = i_oper_cond_1;
    cond_in[3]  = i_oper_cond_2;
    cond_in[4]  = i_oper_cond_3;
    cond_in[5]  = i_oper_cond_4;
    cond_in[6]  = i_oper_cond_5;
    cond_in[7]  = i_oper_cond_6;
    cond_in[8]  = i_ques_cond_0;
    cond_in[9]  = i_ques_cond_1;
    cond_in[10] = i_ques_cond_2;
  end

  // ---------------------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------------------
  assign exec = (state_q == SRS_ST_EXEC) && !bad_cmd;
  assign bad_cmd = (set_q > SRS_SET_QUES_LAST) || (op_q > SRS_OP_RISE)
                 || (write_q && (op_q == SRS_OP_COND || op_q == SRS_OP_EVENT));

  always_comb begin
    for (int k = 0; k < SRS_NUM_SETS; k++) begin
      rd_event_sel[k] = exec && (set_q == SRS_SET_W'(k)) && !write_q && (op_q == SRS_OP_EVENT);
      wr_en_sel[k]    = exec && (set_q == SRS_SET_W'(k)) && write_q && (op_q == SRS_OP_ENABLE);
      wr_fall_sel[k]  = exec && (set_q == SRS_SET_W'(k)) && write_q && (op_q == SRS_OP_FALL);
      wr_rise_sel[k]  = exec && (set_q == SRS_SET_W'(k)) && write_q && (op_q == SRS_OP_RISE);
    end
  end

  // Sets outside the operation and questionable groups keep their state over a preset.
  for (genvar g = 0; g < SRS_NUM_SETS; g++) begin : g_set
    localparam bit IS_OPER = (g >= 1) && (g <= 7);
    localparam bit IS_QUES = (g >= 8);
    srs_reg_set #(
      .P_PRE_ENABLE (SRS_PRE_ENABLE),
      .P_PRE_RISE   (SRS_PRE_RISE),
      .P_PRE_FALL   (SRS_PRE_FALL),
      .P_PRESET_FILT (IS_OPER)
    ) u_set (
      .i_clock        (i_clock),
      .i_rst_n        (i_rst_n),
      .i_ce           (i_ce),
      .i_cond         (cond_in[g]),
      .i_direct_set   (direct_in[g]),
      .i_preset       (i_status_preset && (IS_OPER || IS_QUES)),
      .i_clear_events (i_clear_status),
      .i_read_event   (rd_event_sel[g]),
      .i_wr_enable    (wr_en_sel[g]),
      .i_wr_fall      (wr_fall_sel[g]),
      .i_wr_rise      (wr_rise_sel[g]),
      .i_wdata        (wdata_q),
      .o_cond         (cond_rd[g]),
      .o_event        (event_rd[g]),
      .o_enable       (enable_rd[g]),
      .o_fall         (fall_rd[g]),
      .o_rise         (rise_rd[g]),
      .o_summary      (summary[g])
    );
  end

  // ---------------------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q     <= SRS_ST_IDLE;
      set_q       <= 4'h0;
      op_q        <= 3'h0;
      write_q     <= 1'b0;
      wdata_q     <= 16'h0000;
      cmd_ready_q <= 1'b1;
    end else if (i_ce) begin
      case (state_q)
        SRS_ST_IDLE: begin
          if (i_cmd_valid) begin
            state_q     <= SRS_ST_EXEC;
            set_q       <= i_cmd_set;
            op_q        <= i_cmd_op;
            write_q     <= i_cmd_write;
            wdata_q     <= i_cmd_wdata;
            cmd_ready_q <= 1'b0;
          end
        end
        SRS_ST_EXEC: begin
          state_q <= SRS_ST_RESP;
        end
        SRS_ST_RESP: begin
          state_q     <= SRS_ST_IDLE;
          cmd_ready_q <= 1'b1;
        end
        default: begin
          state_q     <= SRS_ST_IDLE;
          cmd_ready_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 16'h0000;
      rsp_error_q <= 1'b0;
    end else if (i_ce) begin
      rsp_valid_q <= (state_q == SRS_ST_EXEC);
      if (state_q == SRS_ST_EXEC) begin
        rsp_error_q <= bad_cmd;
        rsp_data_q  <= 16'h0000;
        if (!bad_cmd && !write_q) begin
          case (op_q)
            SRS_OP_COND:   rsp_data_q <= cond_rd[set_q] & SRS_VALID_MASK;
            SRS_OP_EVENT:  rsp_data_q <= event_rd[set_q];
            SRS_OP_ENABLE: rsp_data_q <= enable_rd[set_q];
            SRS_OP_FALL:   rsp_data_q <= fall_rd[set_q];
            SRS_OP_RISE:   rsp_data_q <= rise_rd[set_q];
            default:       rsp_data_q <= 16'h0000;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Summaries and error queue controls
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      summary_q     <= 11'h000;
      queue_en_q    <= SRS_PRE_QUEUE_EN;
      clear_queue_q <= 1'b1;
    end else if (i_ce) begin
      summary_q     <= summary;
      clear_queue_q <= i_clear_status;
      if (i_status_preset) begin
        queue_en_q <= SRS_PRE_QUEUE_EN;
      end
    end
  end

  assign o_cmd_ready    = cmd_ready_q;
  assign o_rsp_valid    = rsp_valid_q;
  assign o_rsp_data     = rsp_data_q;
  assign o_rsp_error    = rsp_error_q;
  assign o_summary      = summary_q;
  assign o_queue_enable = queue_en_q;
  assign o_clear_queue  = clear_queue_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_rsp_timing: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && state_q == SRS_ST_IDLE && i_cmd_valid) ##1 i_ce[*2] |-> o_rsp_valid)
    else $error("response did not follow command by two cycles");
  chk_rsp_range: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_rsp_valid |-> !o_rsp_data[15])
    else $error("response exceeds 15 bits");
  chk_key_cond: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    cond_rd[0][SRS_BIT_KEY] == 1'b0 && (cond_rd[0] & ~SRS_SENSOR_MASK) == 16'h0000)
    else $error("unused sensor condition bit is set");
  chk_key_event: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && i_key_press) |=> event_rd[0][SRS_BIT_KEY])
    else $error("key press not latched");
  chk_conn_bits: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    cond_rd[0][SRS_BIT_CONN_A +: 2] == i_sensor_present)
    else $error("connect bits disagree with sensors");
  chk_event_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && rd_event_sel[1] && $past(i_ce) && $stable(cond_in[1]))
      |=> event_rd[1] == 16'h0000)
    else $error("event not cleared by read");
  chk_preset_oper: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && i_status_preset) |=> enable_rd[1] == SRS_PRE_ENABLE
      && rise_rd[1] == SRS_PRE_RISE && fall_rd[1] == SRS_PRE_FALL
      && enable_rd[8] == SRS_PRE_ENABLE)
    else $error("preset values not applied");
  chk_write_mask: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && wr_en_sel[1] && !i_status_preset) |=> enable_rd[1] == ($past(wdata_q) & SRS_VALID_MASK))
    else $error("enable write not stored masked");
  chk_clear_keep: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_ce && i_clear_status && !i_status_preset && !wr_rise_sel[2]) |=> $stable(rise_rd[2]))
    else $error("clear status altered a filter");

  cov_event_read: cover property (@(posedge i_clock) rd_event_sel[0]);
  cov_write:      cover property (@(posedge i_clock) wr_fall_sel[0]);
  cov_preset:     cover property (@(posedge i_clock) i_status_preset && i_ce);
  cov_error:      cover property (@(posedge i_clock) o_rsp_valid && o_rsp_error);
endmodule
`default_nettype wire

// ### srs_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module srs_ctrl_model (
  input  wire logic        i_clock,
  input  wire logic        i_ready,
  input  wire logic        i_rsp_valid,
  input  wire logic [15:0] i_rsp_data,
  input  wire logic        i_rsp_error,
  output logic             o_valid,
  output logic [3:0]       o_set,
  output logic [2:0]       o_op,
  output logic             o_write,
  output logic [15:0]      o_wdata
);
  initial begin
    o_valid = 1'b0;
    o_set   = 4'h0;
    o_op    = 3'h0;
    o_write = 1'b0;
    o_wdata = 16'h0000;
  end
  // --------------------------------------------------------------------------
  // One command, held until taken, then the answer is collected.
  // --------------------------------------------------------------------------
  task automatic issue(input logic [3:0] s, input logic [2:0] op, input logic w,
                       input logic [15:0] d, output logic [15:0] q, output logic e);
    int n;
    n = 0;
    q = 16'hXXXX;
    e = 1'bx;
    @(negedge i_clock);
    o_valid = 1'b1;
    o_set   = s;
    o_op    = op;
    o_write = w;
    o_wdata = d;
    while (i_ready !== 1'b1 && n < 20) begin
      @(negedge i_clock);
      n++;
    end
    @(negedge i_clock);
    o_valid = 1'b0;
    // A released data bus shows the inverse, so a stale word is never read as live.
    o_wdata = ~o_wdata;
    while (i_rsp_valid !== 1'b1 && n < 40) begin
      @(negedge i_clock);
      n++;
    end
    if (n < 40) begin
      q = i_rsp_data;
      e = i_rsp_error;
    end
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import srs_pkg::*;
  logic        clk, rst_n, ce, clr, pre, key, valid, wr, rdy, rv, re, qen, cq;
  logic [3:0]  set;
  logic [2:0]  op;
  logic [15:0] wd, rd, d, junk;
  logic        jerr;
  logic [1:0]  pres, rear, calf, both;
  logic [15:0] oc [7];
  logic [15:0] qc [3];
  logic [10:0] summ;
  int          err_total, samples_checked, seed;

  srs_top srs_top_i (.i_clock(clk), .i_rst_n(rst_n), .i_ce(ce), .i_cmd_valid(valid),
    .i_cmd_set(set), .i_cmd_op(op), .i_cmd_write(wr), .i_cmd_wdata(wd),
    .i_clear_status(clr), .i_status_preset(pre), .i_sensor_present(pres),
    .i_sensor_rear(rear), .i_sensor_cal_fail(calf), .i_sensor_both_ports(both),
    .i_key_press(key), .i_oper_cond_0(oc[0]), .i_oper_cond_1(oc[1]),
    .i_oper_cond_2(oc[2]), .i_oper_cond_3(oc[3]), .i_oper_cond_4(oc[4]),
    .i_oper_cond_5(oc[5]), .i_oper_cond_6(oc[6]), .i_ques_cond_0(qc[0]),
    .i_ques_cond_1(qc[1]), .i_ques_cond_2(qc[2]), .o_cmd_ready(rdy),
    .o_rsp_valid(rv), .o_rsp_data(rd), .o_rsp_error(re), .o_summary(summ),
    .o_queue_enable(qen), .o_clear_queue(cq));
  srs_ctrl_model srs_ctrl_model_i (.i_clock(clk), .i_ready(rdy), .i_rsp_valid(rv),
    .i_rsp_data(rd), .i_rsp_error(re), .o_valid(valid), .o_set(set), .o_op(op),
    .o_write(wr), .o_wdata(wd));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [15:0] sens(input logic [1:0] p, r, c, b);
    return {9'h000, r & p, c | b, p, 1'b0};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic [3:0] s, input logic [2:0] o, input logic w,
                     input logic [15:0] v, input logic [15:0] exp, input logic ee);
    logic [15:0] q;
    logic        e;
    srs_ctrl_model_i.issue(s, o, w, v, q, e);
    chk(q, exp);
    chk({15'h0000, e}, {15'h0000, ee});
  endtask

  task automatic settle();
    repeat (3) @(negedge clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #(20 * 30000);
    err_total++;
    finish_test();
  end

  initial begin
    seed = 66292;
    {rst_n, ce, clr, pre, key} = 5'b01000;
    {pres, rear, calf, both} = 8'h00;
    foreach (oc[k]) oc[k] = 16'h0000;
    foreach (qc[k]) qc[k] = 16'h0000;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk({15'h0000, qen}, 16'h0001);
    for (int s = 0; s < 11; s++) begin
      acc(4'(s), 3'h2, 1'b0, 16'h0000, 16'h0000, 1'b0);
      acc(4'(s), 3'h3, 1'b0, 16'h0000, 16'h0000, 1'b0);
      acc(4'(s), 3'h4, 1'b0, 16'h0000, 16'h7FFF, 1'b0);
      acc(4'(s), 3'h1, 1'b0, 16'h0000, 16'h0000, 1'b0);
    end
    $display("test reset values done");
    for (int s = 0; s < 11; s++) begin
      for (int o = 2; o < 5; o++) begin
        d = (s == 1) ? 16'hFFFF : 16'($random(seed));
        acc(4'(s), 3'(o), 1'b1, d, 16'h0000, 1'b0);
        acc(4'(s), 3'(o), 1'b0, 16'h0000, d & 16'h7FFF, 1'b0);
      end
    end
    $display("test write readback done");
    foreach (oc[k]) oc[k] = 16'($random(seed));
    foreach (qc[k]) qc[k] = 16'($random(seed));
    settle();
    for (int s = 1; s < 11; s++) begin
      d = (s < 8) ? oc[s - 1] : qc[s - 8];
      repeat (2) acc(4'(s), 3'h0, 1'b0, 16'h0000, d & 16'h7FFF, 1'b0);
    end
    $display("test condition read done");
    acc(4'h0, 3'h3, 1'b1, 16'h0002, 16'h0000, 1'b0);
    acc(4'h0, 3'h4, 1'b1, 16'h0004, 16'h0000, 1'b0);
    acc(4'h0, 3'h1, 1'b0, 16'h0000, 16'h0000, 1'b0);
    pres = 2'b11;
    settle();
    acc(4'h0, 3'h0, 1'b0, 16'h0000, 16'h0006, 1'b0);
    acc(4'h0, 3'h1, 1'b0, 16'h0000, 16'h0004, 1'b0);
    acc(4'h0, 3'h1, 1'b0, 16'h0000, 16'h0000, 1'b0);
    pres = 2'b00;
    settle();
    acc(4'h0, 3'h1, 1'b0, 16'h0000, 16'h0002, 1'b0);
    for (int k = 0; k < 12; k++) begin
      {pres, rear, calf, both} = 8'($random(seed));
      settle();
      acc(4'h0, 3'h0, 1'b0, 16'h0000, sens(pres, rear, calf, both), 1'b0);
    end
    acc(4'h0, 3'h2, 1'b1, 16'h4000, 16'h0000, 1'b0);
    srs_ctrl_model_i.issue(4'h0, 3'h1, 1'b0, 16'h0000, junk, jerr);
    key = 1'b1;
    @(negedge clk);
    key = 1'b0;
    settle();
    chk({15'h0000, summ[0]}, 16'h0001);
    acc(4'h0, 3'h0, 1'b0, 16'h0000, sens(pres, rear, calf, both), 1'b0);
    acc(4'h0, 3'h1, 1'b0, 16'h0000, 16'h4000, 1'b0);
    settle();
    chk({15'h0000, summ[0]}, 16'h0000);
    $display("test sensor set done");
    acc(4'h1, 3'h2, 1'b1, 16'h8421, 16'h0000, 1'b0);
    oc[0] = 16'h00FF;
    settle();
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    chk({15'h0000, cq}, 16'h0001);
    for (int s = 0; s < 11; s++)
      acc(4'(s), 3'h1, 1'b0, 16'h0000, 16'h0000, 1'b0);
    acc(4'h1, 3'h2, 1'b0, 16'h0000, 16'h0421, 1'b0);
    $display("test clear status done");
    acc(4'h2, 3'h2, 1'b1, 16'h1234, 16'h0000, 1'b0);
    acc(4'h2, 3'h3, 1'b1, 16'h00F0, 16'h0000, 1'b0);
    acc(4'h2, 3'h4, 1'b1, 16'h000F, 16'h0000, 1'b0);
    acc(4'h8, 3'h2, 1'b1, 16'h0055, 16'h0000, 1'b0);
    acc(4'h8, 3'h3, 1'b1, 16'h0033, 16'h0000, 1'b0);
    pre = 1'b1;
    @(negedge clk);
    pre = 1'b0;
    acc(4'h2, 3'h2, 1'b0, 16'h0000, 16'h0000, 1'b0);
    acc(4'h2, 3'h3, 1'b0, 16'h0000, 16'h0000, 1'b0);
    acc(4'h2, 3'h4, 1'b0, 16'h0000, 16'h7FFF, 1'b0);
    acc(4'h8, 3'h2, 1'b0, 16'h0000, 16'h0000, 1'b0);
    acc(4'h8, 3'h3, 1'b0, 16'h0000, 16'h0033, 1'b0);
    acc(4'h0, 3'h2, 1'b0, 16'h0000, 16'h4000, 1'b0);
    chk({15'h0000, qen}, 16'h0001);
    $display("test status preset done");
    ce = 1'b0;
    key = 1'b1;
    repeat (2) @(negedge clk);
    key = 1'b0;
    ce = 1'b1;
    acc(4'h0, 3'h1, 1'b0, 16'h0000, 16'h0000, 1'b0);
    $display("test clock enable freeze done");
    acc(4'hB, 3'h0, 1'b0, 16'h0000, 16'h0000, 1'b1);
    acc(4'hF, 3'h1, 1'b0, 16'h0000, 16'h0000, 1'b1);
    acc(4'h1, 3'h5, 1'b0, 16'h0000, 16'h0000, 1'b1);
    acc(4'h0, 3'h0, 1'b1, 16'h1111, 16'h0000, 1'b1);
    acc(4'h3, 3'h1, 1'b1, 16'h2222, 16'h0000, 1'b1);
    $display("test refused commands done");
    finish_test();
  end
endmodule
`default_nettype wire
